/* File: core/serial_mode_regs.vh */
// Opcodes, mode register layout and link lane codes for the mode register
`ifndef SERIAL_MODE_REGS_VH
`define SERIAL_MODE_REGS_VH

// Instruction opcodes, eight bits each
`define READ_MODE_REG_CMD 8'h05
`define WRITE_MODE_REG_CMD 8'h01

// Mode register reset value: burst mode, pause enabled
`define MODE_CFG_RESET 8'h40

// Field positions
`define MODE_PAUSE_DIS_BIT 0
`define MODE_OP_HI_BIT 7
`define MODE_OP_LO_BIT 6

// Operating mode field encodings
`define OP_MODE_WORD 2'h0
`define OP_MODE_BURST 2'h1
`define OP_MODE_PAGE 2'h2
`define OP_MODE_RSVD 2'h3

// Link width codes on the lane_mode pins
`define LANE_SINGLE 2'h0
`define LANE_DUAL 2'h1
`define LANE_QUAD 2'h2

// Bits in one byte on the link
`define BYTE_BITS 4'h8

`endif

/* File: core/in_sync2.v */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps

module in_sync2 #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Asynchronous input and its synchronised copy
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_reg;
			reg sync_reg;
			// Resets high so an idle link looks deselected
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg <= 1'b1;
					sync_reg <= 1'b1;
				end else begin
					meta_reg <= d[i];
					sync_reg <= meta_reg;
				end
			end
			assign q[i] = sync_reg;
		end
	endgenerate

endmodule // in_sync2

/* File: core/sram_mode_reg_top.v */
// Serial link access logic for the operating mode register
`timescale 1ns/10ps
`include "serial_mode_regs.vh"

module sram_mode_reg_top (
	// System clock and reset
	input wire ref_clk,
	input wire nrst,
	// Serial link pins
	input wire select_n,
	input wire serial_clk,
	input wire pause_n,
	input wire [1:0] lane_mode,
	input wire [3:0] data_lines_in,
	output wire [3:0] data_lines_out,
	output wire [3:0] data_lines_oe,
	// Mode register state
	output wire [7:0] mode_cfg,
	output wire pause_disabled,
	output wire [1:0] op_mode
);

	// Frame states
	localparam ST_CMD = 2'h0;
	localparam ST_READ = 2'h1;
	localparam ST_WRITE = 2'h2;
	localparam ST_IGNORE = 2'h3;

	// Reset synchroniser, pin copies and edge flags
	reg rst_meta_reg;
	reg rst_sync_reg;
	wire rst_n;
	wire [8:0] pins_s;
	wire sel_n_s;
	wire sclk_s;
	wire pause_n_s;
	wire [1:0] lane_s;
	wire [3:0] din_s;
	reg sclk_prev_reg;
	wire sclk_rise;
	wire sclk_fall;
	wire paused;
	reg [1:0] state_reg;
	reg [3:0] in_cnt_reg;
	reg [7:0] in_sh_reg;
	reg [3:0] out_cnt_reg;
	reg [7:0] out_sh_reg;
	reg [7:0] operating_mode_config_reg;
	reg [3:0] dout_reg;
	reg [3:0] doe_reg;
	reg [7:0] in_next;
	reg [3:0] step;
	reg [3:0] lane_out;
	reg [3:0] lane_oe;
	reg [7:0] out_shifted;
	wire [3:0] in_cnt_next;
	wire [3:0] out_cnt_next;

	// Reset release through two flip-flops
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// All link pins pass two flip-flops before use
	in_sync2 #(
		.WIDTH(9)
	) u_pin_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.d({lane_mode, pause_n, select_n, serial_clk, data_lines_in}),
		.q(pins_s)
	);
	assign din_s = pins_s[3:0];
	assign sclk_s = pins_s[4];
	assign sel_n_s = pins_s[5];
	assign pause_n_s = pins_s[6];
	assign lane_s = pins_s[8:7];

	// Serial clock edge detection on the synchronised copy
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b1;
		end else begin
			sclk_prev_reg <= sclk_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_prev_reg;
	assign sclk_fall = ~sclk_s & sclk_prev_reg;

	// Pause freezes the transfer unless disabled or in quad mode
	assign paused = ~pause_n_s &
		~operating_mode_config_reg[`MODE_PAUSE_DIS_BIT] &
		(lane_s != `LANE_QUAD);

	// Input shift and output lane mapping per link width
	always @* begin
		case (lane_s)
			`LANE_DUAL: begin
				in_next = {in_sh_reg[5:0], din_s[1:0]};
				step = 4'h2;
				lane_out = {2'h0, out_sh_reg[7:6]};
				lane_oe = 4'h3;
				out_shifted = {out_sh_reg[5:0], 2'h0};
			end
			`LANE_QUAD: begin
				in_next = {in_sh_reg[3:0], din_s[3:0]};
				step = 4'h4;
				lane_out = out_sh_reg[7:4];
				lane_oe = 4'hf;
				out_shifted = {out_sh_reg[3:0], 4'h0};
			end
			default: begin
				in_next = {in_sh_reg[6:0], din_s[0]};
				step = 4'h1;
				lane_out = {2'h0, out_sh_reg[7], 1'b0};
				lane_oe = 4'h2;
				out_shifted = {out_sh_reg[6:0], 1'b0};
			end
		endcase
	end
	assign in_cnt_next = in_cnt_reg + step;
	assign out_cnt_next = out_cnt_reg + step;

	// Command decode, register write and read shifting
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_CMD;
			in_cnt_reg <= 4'h0;
			in_sh_reg <= 8'h00;
			out_cnt_reg <= 4'h0;
			out_sh_reg <= 8'h00;
			operating_mode_config_reg <= `MODE_CFG_RESET;
			dout_reg <= 4'h0;
			doe_reg <= 4'h0;
		end else if (sel_n_s) begin
			// Deselected: idle and release the lines
			state_reg <= ST_CMD;
			in_cnt_reg <= 4'h0;
			out_cnt_reg <= 4'h0;
			doe_reg <= 4'h0;
			dout_reg <= 4'h0;
		end else if (!paused) begin
			if (sclk_rise) begin
				case (state_reg)
					ST_CMD: begin
						in_sh_reg <= in_next;
						in_cnt_reg <= in_cnt_next;
						if (in_cnt_next == `BYTE_BITS) begin
							in_cnt_reg <= 4'h0;
							if (in_next == `READ_MODE_REG_CMD) begin
								state_reg <= ST_READ;
								out_sh_reg <= operating_mode_config_reg;
								out_cnt_reg <= 4'h0;
							end else if (in_next == `WRITE_MODE_REG_CMD) begin
								state_reg <= ST_WRITE;
							end else begin
								state_reg <= ST_IGNORE;
							end
						end
					end
					ST_WRITE: begin
						in_sh_reg <= in_next;
						in_cnt_reg <= in_cnt_next;
						if (in_cnt_next == `BYTE_BITS) begin
							// Bits 5:1 stored but unused
							operating_mode_config_reg <= in_next;
							state_reg <= ST_IGNORE;
						end
					end
					// Unknown opcode or finished write: rest of frame ignored
					default: begin
						state_reg <= state_reg;
					end
				endcase
			end else if (sclk_fall && state_reg == ST_READ) begin
				// First fall after the opcode drives the first bits
				dout_reg <= lane_out;
				doe_reg <= lane_oe;
				if (out_cnt_next == `BYTE_BITS) begin
					out_sh_reg <= operating_mode_config_reg;
					out_cnt_reg <= 4'h0;
				end else begin
					out_sh_reg <= out_shifted;
					out_cnt_reg <= out_cnt_next;
				end
			end
		end
	end

	// Outputs come straight from registers
	assign data_lines_out = dout_reg;
	assign data_lines_oe = doe_reg;
	assign mode_cfg = operating_mode_config_reg;
	assign pause_disabled = operating_mode_config_reg[`MODE_PAUSE_DIS_BIT];
	assign op_mode = operating_mode_config_reg[`MODE_OP_HI_BIT:`MODE_OP_LO_BIT];

endmodule // sram_mode_reg_top

/* File: sim/mode_reg_sva.sv */
// Port checker for the mode register link block
`timescale 1ns/10ps
module mode_reg_sva (
	// Clock, reset and link pins
	input wire ref_clk,
	input wire nrst,
	input wire select_n,
	input wire serial_clk,
	input wire pause_n,
	input wire [1:0] lane_mode,
	// Device outputs
	input wire [3:0] data_lines_out,
	input wire [3:0] data_lines_oe,
	input wire [7:0] mode_cfg,
	input wire pause_disabled,
	input wire [1:0] op_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Deselected and paused stretches, past the pin synchronisers
	sequence s_idle; select_n [*5]; endsequence
	sequence s_held; (!pause_n && !pause_disabled && lane_mode != 2'h2) [*5];
	endsequence
	chk_pause_bit: assert property
		(pause_disabled == mode_cfg[0]) else $error("pause bit");
	chk_mode_field: assert property
		(op_mode == mode_cfg[7:6]) else $error("mode field");
	chk_idle_quiet: assert property
		(s_idle |-> data_lines_oe == 4'h0) else $error("idle drive");
	chk_cfg_in_frame: assert property
		($changed(mode_cfg) |-> !$past(select_n, 3)) else $error("cfg");
	chk_out_on_fall: assert property
		($changed(data_lines_out) |-> !$past(serial_clk, 2)) else $error("out");
	chk_single_lane: assert property
		((lane_mode == 2'h0) [*8] |-> (data_lines_oe & 4'hd) == 4'h0)
		else $error("lane");
	chk_oe_shape: assert property
		(data_lines_oe inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("oe");
	chk_pause_freeze: assert property
		(s_held |-> $stable(mode_cfg) && $stable(data_lines_out))
		else $error("pause");
endmodule // mode_reg_sva
bind sram_mode_reg_top mode_reg_sva i_sva (.*);

/* File: sim/link_host.sv */
// Host model that clocks frames over the serial link
`timescale 1ns/10ps
module link_host (
	// Clock and wire level
	input wire ref_clk,
	input wire [3:0] sio,
	// Pins toward the device
	output reg select_n = 1'b1,
	output reg serial_clk = 1'b0,
	output reg [3:0] hd = 4'h0
);
	// Half a link period is four system clocks
	task half;
		repeat (4) @(negedge ref_clk);
	endtask
	// Opcode, then nb data bits sent or read back over k lanes
	task xfer(input [1:0] lm, input [15:0] sh_in, input integer nb,
		input rd_en, output [7:0] rd);
		integer k, i;
		reg [15:0] sh;
		begin
			k = (lm == 2'h0) ? 1 : (lm == 2'h1) ? 2 : 4;
			sh = sh_in;
			rd = 8'h00;
			select_n = 1'b0;
			half;
			for (i = 0; i < 8 + nb; i = i + k) begin
				hd = (i < 8 || !rd_en) ? sh[15:12] >> (4 - k) : ~hd;
				half;
				serial_clk = 1'b1;
				half;
				rd = (rd << k) | ({4'h0, (k == 1) ? {3'h0, sio[1]} : sio}
					& ((8'h01 << k) - 8'h01));
				sh = sh << k;
				serial_clk = 1'b0;
			end
			half;
			select_n = 1'b1;
			hd = ~hd;
			half;
		end
	endtask
endmodule // link_host

/* File: sim/sram_mode_reg_top_tb.sv */
// Self-checking bench for the mode register link block
`timescale 1ns/10ps
module sram_mode_reg_top_tb;
	reg ref_clk = 1'b0;
	reg nrst = 1'b0;
	reg pause_n = 1'b1;
	reg [1:0] lane_mode = 2'h0;
	reg [7:0] v, rd;
	integer fails = 0, cmp_count = 0, cyc = 0, j;
	wire select_n, serial_clk, pause_disabled;
	wire [3:0] hd, sio, dl_out, dl_oe;
	wire [7:0] mode_cfg;
	wire [1:0] op_mode;
	// Wire level: the device wins on lanes it drives
	assign sio = (dl_oe & dl_out) | (~dl_oe & hd);
	always #50 ref_clk = ~ref_clk;
	link_host i_host (.ref_clk(ref_clk), .sio(sio), .select_n(select_n),
		.serial_clk(serial_clk), .hd(hd));
	sram_mode_reg_top i_dut (.ref_clk(ref_clk), .nrst(nrst),
		.select_n(select_n), .serial_clk(serial_clk), .pause_n(pause_n),
		.lane_mode(lane_mode), .data_lines_in(sio), .data_lines_out(dl_out),
		.data_lines_oe(dl_oe), .mode_cfg(mode_cfg),
		.pause_disabled(pause_disabled), .op_mode(op_mode));
	task check(input [7:0] got, input [7:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("[ERR] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("fails %0d of %0d", fails, cmp_count);
			if (fails == 0 && cmp_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// Cut a hang short
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			conclude;
		end
	end
	// Register write of nb data bits
	task wr(input [1:0] lm, input [7:0] d, input integer nb);
		begin
			lane_mode = lm;
			i_host.xfer(lm, {8'h01, d}, nb, 1'b0, rd);
		end
	endtask
	initial begin
		repeat (20) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (6) @(negedge ref_clk);
		check(mode_cfg, 8'h40);
		check({5'h0, pause_disabled, op_mode}, 8'h01);
		// Every lane width against every operating mode
		for (j = 0; j < 12; j = j + 1) begin
			v = {j[1:0], 6'h2a ^ j[5:0]};
			wr(j % 3, v, 8);
			check(mode_cfg, v);
			check({6'h0, op_mode}, {6'h0, v[7:6]});
			i_host.xfer(j % 3, 16'h0500, 16, 1'b1, rd);
			check(rd, v);
		end
		// Aborted write, then pause in single and quad lanes
		wr(2'h0, 8'hff, 4);
		check(mode_cfg, v);
		wr(2'h0, 8'h00, 8);
		pause_n = 1'b0;
		wr(2'h0, 8'h81, 8);
		check(mode_cfg, 8'h00);
		wr(2'h2, 8'h81, 8);
		check(mode_cfg, 8'h81);
		wr(2'h0, 8'h40, 8);
		check(mode_cfg, 8'h40);
		// Pause in dual lanes, then a dual write and a reset in mid-run
		wr(2'h1, 8'h83, 8);
		check(mode_cfg, 8'h40);
		pause_n = 1'b1;
		wr(2'h1, 8'h83, 8);
		check(mode_cfg, 8'h83);
		nrst = 1'b0;
		repeat (3) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (6) @(negedge ref_clk);
		check({5'h0, pause_disabled, op_mode}, 8'h01);
		check(mode_cfg, 8'h40);
		conclude;
	end
endmodule // sram_mode_reg_top_tb
